// file: hw/fxc_comparator.sv
`timescale 1ns/1ps
module fxc_comparator
#(
  parameter int CYCLES_PER_MS = fxc_pkg::CYCLES_PER_MS
)
(
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       enable_i,
  input  wire logic                       sample_valid_i,
  input  wire logic                       pos_select_i,
  input  wire logic signed [fxc_pkg::VAL_W-1:0] pos_value_i,
  input  wire logic [fxc_pkg::VAL_W-1:0]  pos_base_i,
  input  wire logic                       neg_select_i,
  input  wire logic signed [fxc_pkg::VAL_W-1:0] neg_value_i,
  input  wire logic [fxc_pkg::VAL_W-1:0]  neg_base_i,
  input  wire fxc_pkg::fxc_kind_t         kind_i,
  input  wire logic                       absolute_mode_i,
  input  wire logic                       delta_mode_i,
  input  wire logic                       under_dir_i,
  input  wire logic signed [fxc_pkg::PKP_W-1:0] pickup_mpu_i,
  input  wire logic [fxc_pkg::HYS_W-1:0]  hysteresis_i,
  input  wire fxc_pkg::fxc_unit_t         interval_time_unit_i,
  input  wire logic [fxc_pkg::DT_W-1:0]   rate_interval_length_i,
  input  wire logic [fxc_pkg::DLY_W-1:0]  assert_delay_i,
  input  wire logic [fxc_pkg::DLY_W-1:0]  reset_delay_i,
  output logic                            picked_up_o,
  output logic                            operate_o
);
  import fxc_pkg::*;

  // ==========================================================
  // Time base
  logic [PRE_W-1:0] pre_count;
  logic [SEC_W-1:0] sec_count;
  logic [MIN_W-1:0] min_count;
  logic             ms_tick;
  logic             s_tick;
  logic             min_tick;
  logic             unit_tick;

  assign ms_tick  = (pre_count == PRE_W'(CYCLES_PER_MS - 1));
  assign s_tick   = ms_tick && (sec_count == SEC_W'(MS_PER_S - 1));
  assign min_tick = s_tick && (min_count == MIN_W'(S_PER_MIN - 1));

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pre_count <= RST_PRE;
      sec_count <= RST_SEC;
      min_count <= RST_MIN;
    end
    else
    begin
      pre_count <= ms_tick ? RST_PRE : pre_count + 16'h0001;
      if (ms_tick)
        sec_count <= s_tick ? RST_SEC : sec_count + 10'h001;
      if (s_tick)
        min_count <= min_tick ? RST_MIN : min_count + 6'h01;
    end
  end

  always_comb
  begin
    unique case (interval_time_unit_i)
      FXC_UNIT_MS:  unit_tick = ms_tick;
      FXC_UNIT_S:   unit_tick = s_tick;
      FXC_UNIT_MIN: unit_tick = min_tick;
      default:      unit_tick = 1'b0;
    endcase
  end

  // ==========================================================
  // Operating signal
  logic                     any_select;
  logic signed [DIFF_W-1:0] pos_term;
  logic signed [DIFF_W-1:0] neg_term;
  logic signed [DIFF_W-1:0] diff;
  logic signed [DIFF_W-1:0] next_op;
  logic signed [DIFF_W-1:0] op_value;

  assign any_select = pos_select_i || neg_select_i;
  assign pos_term   = pos_select_i ? DIFF_W'(pos_value_i) : RST_VAL;
  assign neg_term   = neg_select_i ? DIFF_W'(neg_value_i) : RST_VAL;
  assign diff       = pos_term - neg_term;
  assign next_op    = (absolute_mode_i && diff < 0) ? -diff : diff;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      op_value <= RST_VAL;
    else if (sample_valid_i)
      op_value <= next_op;
  end

  a_op_select: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sample_valid_i && !pos_select_i && !neg_select_i |=> op_value == 0)
    else $error("operating signal not zero with inputs off");

  a_abs_magnitude: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sample_valid_i && absolute_mode_i |=> op_value >= 0)
    else $error("absolute mode produced a negative signal");

  // ==========================================================
  // Rate of change
  logic [DT_W-1:0]          int_count;
  logic                     interval_done;
  logic signed [DIFF_W-1:0] rate_ref;
  logic signed [DIFF_W-1:0] rate_value;
  logic                     ref_valid;
  logic                     rate_valid;

  assign interval_done = delta_mode_i && unit_tick && ((int_count + 17'h00001) >= rate_interval_length_i);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      int_count <= RST_DT;
    else if (!delta_mode_i || interval_done)
      int_count <= RST_DT;
    else if (unit_tick)
      int_count <= int_count + 17'h00001;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rate_ref   <= RST_VAL;
      rate_value <= RST_VAL;
      ref_valid  <= 1'b0;
      rate_valid <= 1'b0;
    end
    else if (!delta_mode_i)
    begin
      ref_valid  <= 1'b0;
      rate_valid <= 1'b0;
    end
    else if (interval_done)
    begin
      rate_ref   <= op_value;
      rate_value <= op_value - rate_ref;
      ref_valid  <= 1'b1;
      rate_valid <= ref_valid;
    end
  end

  a_level_no_interval: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !delta_mode_i |=> (int_count == RST_DT) && !rate_valid)
    else $error("interval counter ran in level mode");

  a_delta_rate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    interval_done |=> rate_value == $past(op_value) - $past(rate_ref))
    else $error("rate not taken over the interval");

  // ==========================================================
  // Per-unit base and threshold
  logic [VAL_W-1:0]         max_base;
  logic [VAL_W-1:0]         base;
  logic signed [WIDE_W-1:0] thr;
  logic signed [WIDE_W-1:0] thr_mag;
  logic signed [WIDE_W-1:0] band;
  logic signed [WIDE_W-1:0] eff;
  logic                     eff_valid;

  assign max_base = (!neg_select_i || (pos_select_i && pos_base_i >= neg_base_i)) ? pos_base_i : neg_base_i;

  always_comb
  begin
    unique case (kind_i)
      FXC_KIND_MILLIAMP:  base = max_base;
      FXC_KIND_ANGLE:     base = BASE_ANGLE_DEG;
      FXC_KIND_ENERGY:    base = BASE_ENERGY_MWH;
      FXC_KIND_SOURCE_IV: base = max_base;
      FXC_KIND_HARMONIC:  base = BASE_HARMONIC_PCT;
      FXC_KIND_XFMR:      base = max_base;
      FXC_KIND_GENERIC:   base = max_base;
      default:            base = max_base;
    endcase
  end

  assign thr       = (WIDE_W'(pickup_mpu_i) * $signed(WIDE_W'(base))) / $signed(PU_SCALE);
  assign thr_mag   = (thr < 0) ? -thr : thr;
  assign band      = (thr_mag * $signed(WIDE_W'(hysteresis_i))) / $signed(HYS_SCALE);
  assign eff       = delta_mode_i ? WIDE_W'(rate_value) : WIDE_W'(op_value);
  assign eff_valid = enable_i && any_select && (!delta_mode_i || rate_valid);

  a_angle_base: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    kind_i == FXC_KIND_ANGLE |-> base == BASE_ANGLE_DEG)
    else $error("angle base wrong");

  // ==========================================================
  // Hysteretic pickup
  logic set_over;
  logic set_under;
  logic clr_over;
  logic clr_under;
  logic next_picked;

  assign set_over    = eff > thr;
  assign set_under   = eff < thr;
  assign clr_over    = eff < (thr - band);
  assign clr_under   = eff > (thr + band);
  assign next_picked = !eff_valid ? 1'b0 :
                       under_dir_i ? (picked_up_o ? !clr_under : set_under) :
                                     (picked_up_o ? !clr_over : set_over);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      picked_up_o <= 1'b0;
    else
      picked_up_o <= next_picked;
  end

  a_over_pickup: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    eff_valid && !under_dir_i && eff > thr |=> picked_up_o)
    else $error("over pickup missed");

  a_under_pickup: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    eff_valid && under_dir_i && eff < thr |=> picked_up_o)
    else $error("under pickup missed");

  a_hyst_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    eff_valid && picked_up_o && !under_dir_i && eff >= thr - band |=> picked_up_o)
    else $error("over dropout inside band");

  a_hyst_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    eff_valid && picked_up_o && under_dir_i && eff > thr + band |=> !picked_up_o)
    else $error("under dropout missed");

  // ==========================================================
  // Assert and reset delays
  fxc_out_t state;
  logic     pkp_done;
  logic     drop_done;

  fxc_persist_timer u_assert_timer
  (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .cond_i    (picked_up_o),
    .tick_i    (ms_tick),
    .delay_i   (assert_delay_i),
    .done_o    (pkp_done)
  );

  fxc_persist_timer u_reset_timer
  (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .cond_i    (!picked_up_o),
    .tick_i    (ms_tick),
    .delay_i   (reset_delay_i),
    .done_o    (drop_done)
  );

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= FXC_OUT_RESET;
    else
    begin
      unique case (state)
        FXC_OUT_RESET:   if (pkp_done) state <= FXC_OUT_OPERATE;
        FXC_OUT_OPERATE: if (drop_done) state <= FXC_OUT_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      operate_o <= 1'b0;
    else
      operate_o <= (state == FXC_OUT_RESET) ? pkp_done : !drop_done;
  end

  sequence s_picked_held;
    picked_up_o && pkp_done;
  endsequence

  a_assert_delay: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(operate_o) |-> $past(picked_up_o && pkp_done))
    else $error("output asserted before the assert delay");

  a_assert_follow: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_picked_held |=> operate_o)
    else $error("output missed after the assert delay");

  a_reset_delay: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $fell(operate_o) |-> $past(!picked_up_o && drop_done))
    else $error("output cleared before the reset delay");

  a_no_input_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !any_select [*2] |-> !picked_up_o)
    else $error("pickup with no input selected");

endmodule

// file: hw/fxc_persist_timer.sv
`timescale 1ns/1ps
module fxc_persist_timer
(
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     cond_i,
  input  wire logic                     tick_i,
  input  wire logic [fxc_pkg::DLY_W-1:0] delay_i,
  output logic                          done_o
);
  import fxc_pkg::*;

  logic [DLY_W-1:0] count;
  logic             count_up;

  // ==========================================================
  // Persistence counter
  assign count_up = cond_i && tick_i && (count < delay_i);
  assign done_o   = cond_i && (count >= delay_i);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      count <= RST_DLY;
    else if (!cond_i)
      count <= RST_DLY;
    else if (count_up)
      count <= count + 16'h0001;
  end

  a_timer_restart: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !cond_i |=> (count == RST_DLY))
    else $error("persistence count did not restart");

endmodule

// file: hw/fxc_pkg.sv
// Notes on behaviour
// - Over direction picks up once the operating signal rises above the threshold.
// - Under direction picks up once the operating signal drops below the threshold.
// - Dropout uses a hysteresis band sized in thousandths of the threshold magnitude.
// - Operating signal and threshold are both signed and may be negative.
// - Interval time unit only matters in Delta mode; Level mode ignores it.
// - Delta mode measures change over an interval of the programmed length.
// - Output asserts only after pickup has persisted for the assert delay.
// - Output deasserts only after dropout has persisted for the reset delay.
// - Milliamp transducer base is the larger of the two selected range maxima.
// - Phase angle base is 360 degrees per unit.
// - Energy base is 10000 MWh or MVAh per unit.
// - Source current and voltage base is the larger selected nominal primary.
// - Harmonic and distortion base is 100 percent of the fundamental.
// - Differential and restraint current base is the larger selected primary value.
// - Operating signal is positive minus negative input; an Off input gives zero.
// - With no input selected the output never asserts.
// - Absolute mode uses the magnitude of the difference, Signed uses it directly.
// - Delta mode compares the rate of change instead of the level.
package fxc_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS         = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S      = 1000;
  localparam int S_PER_MIN     = 60;

  // ==========================================================
  // Widths
  localparam int VAL_W  = 32;
  localparam int DIFF_W = 33;
  localparam int WIDE_W = 64;
  localparam int PKP_W  = 18;
  localparam int HYS_W  = 10;
  localparam int DT_W   = 17;
  localparam int DLY_W  = 16;
  localparam int PRE_W  = 16;
  localparam int SEC_W  = 10;
  localparam int MIN_W  = 6;

  // ==========================================================
  // Scaling and bases
  localparam logic [WIDE_W-1:0] PU_SCALE          = 64'h0000_0000_0000_03E8;
  localparam logic [WIDE_W-1:0] HYS_SCALE         = 64'h0000_0000_0000_03E8;
  localparam logic [VAL_W-1:0]  BASE_ANGLE_DEG    = 32'h0000_0168;
  localparam logic [VAL_W-1:0]  BASE_ENERGY_MWH   = 32'h0000_2710;
  localparam logic [VAL_W-1:0]  BASE_HARMONIC_PCT = 32'h0000_0064;

  // ==========================================================
  // Reset values
  localparam logic [PRE_W-1:0]  RST_PRE   = 16'h0000;
  localparam logic [SEC_W-1:0]  RST_SEC   = 10'h000;
  localparam logic [MIN_W-1:0]  RST_MIN   = 6'h00;
  localparam logic [DT_W-1:0]   RST_DT    = 17'h00000;
  localparam logic [DIFF_W-1:0] RST_VAL   = 33'h0_0000_0000;
  localparam logic [DLY_W-1:0]  RST_DLY   = 16'h0000;

  // ==========================================================
  // Modes
  typedef enum logic [2:0] {
    FXC_KIND_GENERIC,
    FXC_KIND_MILLIAMP,
    FXC_KIND_ANGLE,
    FXC_KIND_ENERGY,
    FXC_KIND_SOURCE_IV,
    FXC_KIND_HARMONIC,
    FXC_KIND_XFMR
  } fxc_kind_t;

  typedef enum logic [1:0] {
    FXC_UNIT_MS,
    FXC_UNIT_S,
    FXC_UNIT_MIN
  } fxc_unit_t;

  typedef enum logic {
    FXC_OUT_RESET,
    FXC_OUT_OPERATE
  } fxc_out_t;

endpackage

// file: test/fxc_comparator_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("FAIL %0t got %0b expected %0b", $time, got, exp); \
    end \
  end

module fxc_comparator_tb;
  import fxc_pkg::*;
  localparam int CPM   = 4;
  localparam int LIMIT = 6000;
  logic                    clk_i = 0;
  logic                    reset_n_i = 0;
  logic                    enable_i = 1;
  logic                    sample_valid_i = 0;
  logic                    pos_select_i = 1;
  logic                    neg_select_i = 0;
  logic signed [VAL_W-1:0] pos_value_i = 0;
  logic signed [VAL_W-1:0] neg_value_i = 0;
  logic [VAL_W-1:0]        pos_base_i = 1000;
  logic [VAL_W-1:0]        neg_base_i = 1000;
  fxc_kind_t               kind_i = FXC_KIND_GENERIC;
  logic                    absolute_mode_i = 0;
  logic                    delta_mode_i = 0;
  logic                    under_dir_i = 0;
  logic signed [PKP_W-1:0] pickup_mpu_i = 5000;
  logic [HYS_W-1:0]        hysteresis_i = 100;
  fxc_unit_t               interval_time_unit_i = FXC_UNIT_MS;
  logic [DT_W-1:0]         rate_interval_length_i = 20;
  logic [DLY_W-1:0]        assert_delay_i = 0;
  logic [DLY_W-1:0]        reset_delay_i = 0;
  logic                    picked_up_o;
  logic                    operate_o;
  int                      bad_count = 0;
  int                      compares = 0;
  int                      cycles = 0;
  int                      k;
  logic                    exp_pick = 0;
  longint                  last_eff = 0;

  fxc_comparator #(.CYCLES_PER_MS(CPM)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .enable_i(enable_i),
    .sample_valid_i(sample_valid_i), .pos_select_i(pos_select_i), .pos_value_i(pos_value_i),
    .pos_base_i(pos_base_i), .neg_select_i(neg_select_i), .neg_value_i(neg_value_i), .neg_base_i(neg_base_i),
    .kind_i(kind_i), .absolute_mode_i(absolute_mode_i), .delta_mode_i(delta_mode_i), .under_dir_i(under_dir_i),
    .pickup_mpu_i(pickup_mpu_i), .hysteresis_i(hysteresis_i), .interval_time_unit_i(interval_time_unit_i),
    .rate_interval_length_i(rate_interval_length_i), .assert_delay_i(assert_delay_i),
    .reset_delay_i(reset_delay_i), .picked_up_o(picked_up_o), .operate_o(operate_o));

  // ==========================================================
  // Clock and timeout
  always #12.5 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================================
  // Expected pickup state
  function automatic longint op_now();
    longint v;
    v = (pos_select_i ? longint'(pos_value_i) : 0) - (neg_select_i ? longint'(neg_value_i) : 0);
    if (absolute_mode_i && v < 0) v = -v;
    return v;
  endfunction

  function automatic logic model(input logic prev, input longint eff);
    longint mx, b, thr, band;
    mx = 0;
    if (pos_select_i) mx = longint'(pos_base_i);
    if (neg_select_i && longint'(neg_base_i) > mx) mx = longint'(neg_base_i);
    case (kind_i)
      FXC_KIND_ANGLE:    b = 360;
      FXC_KIND_ENERGY:   b = 10000;
      FXC_KIND_HARMONIC: b = 100;
      default:           b = mx;
    endcase
    thr = longint'(pickup_mpu_i) * b / 1000;
    band = (thr < 0 ? -thr : thr) * longint'(hysteresis_i) / 1000;
    if (!enable_i || !(pos_select_i || neg_select_i)) return 1'b0;
    if (!under_dir_i) return prev ? (eff >= thr - band) : (eff > thr);
    return prev ? (eff <= thr + band) : (eff < thr);
  endfunction

  // ==========================================================
  // Tasks
  task automatic sample(input logic signed [VAL_W-1:0] p, input logic signed [VAL_W-1:0] n, input bit chk);
    logic mid;
    pos_value_i <= p;
    neg_value_i <= n;
    sample_valid_i <= 1'b1;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    @(posedge clk_i);
    #1;
    // New settings meet the old operating signal for one cycle first
    mid = model(exp_pick, last_eff);
    last_eff = op_now();
    exp_pick = model(mid, last_eff);
    if (chk)
    begin
      `CHK(picked_up_o, exp_pick)
      @(posedge clk_i);
      #1;
      `CHK(operate_o, exp_pick)
    end
  endtask

  task automatic wait_out(input bit op, input logic val, input int lim, output int cnt);
    cnt = 0;
    while (((op ? operate_o : picked_up_o) !== val) && cnt < lim)
    begin
      @(posedge clk_i);
      #1;
      cnt++;
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'hF706));
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      under_dir_i <= (i >= 4);
      pickup_mpu_i <= (i >= 4) ? -18'sh01388 : 18'sh01388;
      sample(i < 4 ? 5000 - (i%4 == 0 ? 0 : 0) + (i == 1) - 500 * (i >= 2) - (i == 3) :
             -5000 - (i == 5) + 500 * (i >= 6) + (i == 7), 0, 1);
    end
    for (int i = 0; i < 100; i++)
    begin
      @(posedge clk_i);
      kind_i <= fxc_kind_t'($urandom_range(0, 6));
      pos_select_i <= $urandom_range(0, 3) != 0;
      neg_select_i <= $urandom_range(0, 1);
      pos_base_i <= $urandom_range(1, 100000);
      neg_base_i <= $urandom_range(1, 100000);
      absolute_mode_i <= $urandom_range(0, 1);
      under_dir_i <= $urandom_range(0, 1);
      enable_i <= $urandom_range(0, 7) != 0;
      pickup_mpu_i <= 18'($urandom_range(0, 180000) - 90000);
      hysteresis_i <= 10'($urandom_range(1, 500));
      interval_time_unit_i <= fxc_unit_t'($urandom_range(0, 2));
      rate_interval_length_i <= 17'($urandom_range(20, 86400));
      sample(32'($urandom_range(0, 400000) - 200000), 32'($urandom_range(0, 400000) - 200000), 1);
    end
    @(posedge clk_i);
    kind_i <= FXC_KIND_GENERIC;
    {pos_select_i, neg_select_i, absolute_mode_i, under_dir_i, enable_i} <= 5'b10001;
    pos_base_i <= 1000;
    pickup_mpu_i <= 5000;
    hysteresis_i <= 30;
    assert_delay_i <= 3;
    reset_delay_i <= 2;
    sample(0, 0, 0);
    repeat (20) @(posedge clk_i);
    sample(6000, 0, 0);
    @(posedge clk_i);
    sample(0, 0, 0);
    wait_out(1, 1, 30, k);
    `CHK(k, 30)
    @(posedge clk_i);
    sample(6000, 0, 0);
    wait_out(1, 1, 3 * CPM + 3, k);
    `CHK(k >= 2 * CPM && k <= 3 * CPM + 2, 1'b1)
    @(posedge clk_i);
    sample(0, 0, 0);
    wait_out(1, 0, 2 * CPM + 3, k);
    `CHK(k >= CPM && k <= 2 * CPM + 2, 1'b1)
    @(posedge clk_i);
    delta_mode_i <= 1'b1;
    interval_time_unit_i <= FXC_UNIT_MS;
    rate_interval_length_i <= 20;
    assert_delay_i <= 0;
    reset_delay_i <= 0;
    repeat (250) @(posedge clk_i);
    #1;
    `CHK(picked_up_o, 1'b0)
    @(posedge clk_i);
    sample(6000, 0, 0);
    wait_out(0, 1, 170, k);
    `CHK(k < 170, 1'b1)
    wait_out(0, 0, 90, k);
    `CHK(k < 90, 1'b1)
    summarize();
  end
endmodule
